/* hw/nrp_pkg.sv */
// Shared constants, types and timing for the flash read/program sequencer
package nrp_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int ERASE_TIME_US = 4000;
  localparam int WRITE_TIME_US = 3000;
  localparam int PROGRAM_TIME_US = 7000;
  localparam int REFRESH_TIME_US = 7000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int PROGRAM_CYCLES = ERASE_CYCLES + WRITE_CYCLES;
  localparam int REFRESH_CYCLES = REFRESH_TIME_US * CLK_MHZ;
  localparam int ARRAY_READ_CYCLES = 3;
  localparam int DISTURB_PERIOD = 1000;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int BLOCK_BITS = 64;
  localparam int CHECK_BITS = 8;
  localparam int CODE_BITS = BLOCK_BITS + CHECK_BITS;
  localparam int BLOCKS_PER_PAGE = 16;
  localparam int PHYS_PAGES = 33;
  localparam int LOGIC_PAGES = 32;
  localparam int ADDR_BITS = 17;
  // ****************************************
  // Reset values and bus encodings
  // ****************************************
  localparam logic [7:0] REPAIR_RESET = 8'h00;
  localparam logic [1:0] STARTUP_RESET = 2'h0;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
  } nrp_ahb_req_t;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000,
    SQ_ERASE = 3'b001,
    SQ_WRITE = 3'b010,
    SQ_VERIFY = 3'b011,
    SQ_REFRESH = 3'b100,
    SQ_RMW = 3'b101
  } nrp_seq_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_FETCH = 2'b01,
    RD_DONE = 2'b10
  } nrp_rd_t;
endpackage

/* hw/nrp_ecc.sv */
// Block check-bit encoder and single-correct double-detect decoder
`timescale 1ns/1ps
module nrp_ecc (
  input wire logic [63:0] i_data,
  input wire logic [7:0] i_check,
  output logic [7:0] o_check,
  output logic [63:0] o_data,
  output logic o_single,
  output logic o_double
);
  // ****************************************
  // Hamming code over 64 bits plus overall parity
  // ****************************************
  logic [6:0] pos [64];
  logic [6:0] syn_calc;
  logic [6:0] syn;
  logic par;

  generate
    for (genvar k = 0; k < 64; k++) begin : g_pos
      // Data bit k at codeword position that is not a power of two
      function automatic logic [6:0] place(input int idx);
        int p;
        int n;
        p = 0;
        n = -1;
        for (int j = 1; j < 128; j++) begin
          if ((j & (j - 1)) != 0 && n < idx) begin
            n = n + 1;
            p = j;
          end
        end
        return p[6:0];
      endfunction
      assign pos[k] = place(k);
    end
  endgenerate

  always_comb begin
    syn_calc = 7'h00;
    for (int k = 0; k < 64; k++) begin
      if (i_data[k]) begin
        syn_calc = syn_calc ^ pos[k];
      end
    end
    o_check = {^i_data ^ ^syn_calc, syn_calc};
    syn = syn_calc ^ i_check[6:0];
    par = ^i_data ^ ^i_check;
    o_single = par;
    o_double = !par && (syn != 7'h00);
    o_data = i_data;
    for (int k = 0; k < 64; k++) begin
      if (par && syn == pos[k]) begin
        o_data[k] = !i_data[k];
      end
    end
  end
endmodule

/* hw/nrp_top.sv */
// Flash read prefetch, ECC and program sequencer core
// Notes on behaviour
// - Erase sequence lasts 4.0 ms, write sequence 3.0 ms per page.
// - Program is erase then write, 7.0 ms in total.
// - With disturb handling, one program in a thousand adds 7.0 ms refresh.
// - Verify reads page at hard-read level, compares with assembly buffer.
// - Program goes to spare physical page; old page stays intact.
// - Torn erase or write is detectable at mapping rebuild after reset.
// - Disturb count over limit triggers refresh, doubling program time.
// - Each 64-bit block corrects one error and detects two.
// - Byte write reads block, merges byte, recodes, writes block back.
// - Array read loads a 64-bit block in 3 clock cycles.
// - Two interleaved buffers; one serves, other prefetches next block.
// - Buffers swap roles once served one drained and other filled.
// - Non-sequential request flushes the latest filled buffer to serve it.
// - Repair routine result is readable in a status register.
// - Startup status reports mapping initialisation pass or fail.
// - Reads during busy sequencer are stalled until idle.
// - Read inside a buffered block is served without array access.
// - Page holds 16 blocks plus mapping block, each with check bits.
// - Sector has 33 physical pages, 32 logical plus one spare.
`timescale 1ns/1ps
module nrp_top #(
  parameter int ERASE_CYC = nrp_pkg::ERASE_CYCLES,
  parameter int WRITE_CYC = nrp_pkg::WRITE_CYCLES,
  parameter int REFRESH_CYC = nrp_pkg::REFRESH_CYCLES,
  parameter int DISTURB_PER = nrp_pkg::DISTURB_PERIOD
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic [16:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_prog_start,
  input wire logic [4:0] i_prog_page,
  input wire logic i_disturb_en,
  input wire logic [71:0] i_array_rdata,
  input wire logic [71:0] i_hard_rdata,
  input wire logic i_power_fail,
  input wire logic i_init_done,
  input wire logic i_init_fail,
  input wire logic i_repair_valid,
  input wire logic [7:0] i_repair_code,
  output logic [16:0] o_array_addr,
  output logic o_array_rd,
  output logic [5:0] o_phys_page,
  output logic o_erase_en,
  output logic o_write_en,
  output logic o_busy,
  output logic o_verify_fail,
  output logic o_ecc_err,
  output logic o_torn_mark,
  output logic [7:0] o_repair_result_status,
  output logic [1:0] o_startup_init_status
);
  // ****************************************
  // Registers
  // ****************************************
  nrp_pkg::nrp_seq_t sq_r, sq_nxt;
  nrp_pkg::nrp_rd_t rd_r, rd_nxt;
  nrp_pkg::nrp_ahb_req_t req_r, req_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [9:0] dist_r, dist_nxt;
  logic [5:0] spare_r, spare_nxt;
  logic [5:0] map_r [32];
  logic [5:0] map_nxt [32];
  logic [4:0] page_r, page_nxt;
  logic [3:0] vblk_r, vblk_nxt;
  logic [71:0] abuf_r [16];
  logic [71:0] abuf_nxt [16];
  logic [63:0] rbuf_r [2];
  logic [63:0] rbuf_nxt [2];
  logic [13:0] rtag_r [2];
  logic [13:0] rtag_nxt [2];
  logic [1:0] rval_r, rval_nxt;
  logic srv_r, srv_nxt;
  logic pf_r, pf_nxt;
  logic [1:0] pcnt_r, pcnt_nxt;
  logic [13:0] ftag_r, ftag_nxt;
  logic fbuf_r, fbuf_nxt;
  logic fpf_r, fpf_nxt;
  logic pend_r, pend_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic hready_r, hready_nxt;
  logic hresp_r, hresp_nxt;
  logic vfail_r, vfail_nxt;
  logic eccerr_r, eccerr_nxt;
  logic torn_r, torn_nxt;
  logic [7:0] rep_r, rep_nxt;
  logic [1:0] st_r, st_nxt;
  // Synchronisers for asynchronous status pins
  logic [1:0] pf_s1, pf_s2, init_s1, init_s2;

  // ****************************************
  // ECC on array read and on assembly merge
  // ****************************************
  logic [63:0] rd_corr, mg_data, rmw_corr;
  logic rd_sgl, rd_dbl;
  logic [7:0] mg_chk;
  logic [71:0] rmw_blk;

  nrp_ecc u_rd_ecc (
    .i_data(i_array_rdata[63:0]),
    .i_check(i_array_rdata[71:64]),
    .o_check(),
    .o_data(rd_corr),
    .o_single(rd_sgl),
    .o_double(rd_dbl)
  );

  nrp_ecc u_mg_ecc (
    .i_data(mg_data),
    .i_check(8'h00),
    .o_check(mg_chk),
    .o_data(),
    .o_single(),
    .o_double()
  );

  nrp_ecc u_rmw_ecc (
    .i_data(rmw_blk[63:0]),
    .i_check(rmw_blk[71:64]),
    .o_check(),
    .o_data(rmw_corr),
    .o_single(),
    .o_double()
  );

  logic [13:0] a_tag;
  logic a_new, a_rd, a_wr, a_seq, hit0, hit1;

  always_comb begin
    rmw_blk = abuf_r[i_haddr[6:3]];
    mg_data = rmw_corr;
    for (int b = 0; b < 4; b++) begin
      if (req_r.size == 3'h2 || (req_r.size == 3'h1 && b[1] == req_r.addr[1]) ||
          b[1:0] == req_r.addr[1:0]) begin
        mg_data[{req_r.addr[2], b[1:0], 3'h0} +: 8] = i_hwdata[b*8 +: 8];
      end
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    sq_nxt = sq_r;
    rd_nxt = rd_r;
    req_nxt = req_r;
    tmr_nxt = tmr_r;
    dist_nxt = dist_r;
    spare_nxt = spare_r;
    map_nxt = map_r;
    page_nxt = page_r;
    vblk_nxt = vblk_r;
    abuf_nxt = abuf_r;
    rbuf_nxt = rbuf_r;
    rtag_nxt = rtag_r;
    rval_nxt = rval_r;
    srv_nxt = srv_r;
    pf_nxt = pf_r;
    pcnt_nxt = pcnt_r;
    ftag_nxt = ftag_r;
    fbuf_nxt = fbuf_r;
    fpf_nxt = fpf_r;
    pend_nxt = pend_r;
    hrdata_nxt = hrdata_r;
    hready_nxt = hready_r;
    hresp_nxt = 1'b0;
    vfail_nxt = vfail_r;
    eccerr_nxt = eccerr_r;
    torn_nxt = torn_r;
    rep_nxt = rep_r;
    st_nxt = st_r;
    a_tag = i_haddr[16:3];
    a_new = i_hsel && i_hready && i_htrans[1];
    a_rd = a_new && !i_hwrite;
    a_wr = a_new && i_hwrite;
    a_seq = i_htrans == nrp_pkg::HTRANS_SEQ;
    hit0 = rval_r[0] && rtag_r[0] == a_tag;
    hit1 = rval_r[1] && rtag_r[1] == a_tag;

    if (a_new) begin
      req_nxt = '{addr: i_haddr, trans: i_htrans, write: i_hwrite, size: i_hsize};
    end
    // Byte writes land in the assembly buffer with recomputed check bits
    if (hready_r && req_r.write && pend_r) begin
      abuf_nxt[req_r.addr[6:3]] = {mg_chk, mg_data};
      pend_nxt = 1'b0;
    end
    if (a_wr) begin
      pend_nxt = 1'b1;
    end
    if (a_rd) begin
      if (hit0 || hit1) begin
        hrdata_nxt = hit0 ? rbuf_r[0][i_haddr[2]*32 +: 32] :
                             rbuf_r[1][i_haddr[2]*32 +: 32];
        hready_nxt = 1'b1;
        // Drained buffer refills with the block after the one now served
        if (!hit0 != srv_r) begin
          srv_nxt = !hit0;
          rval_nxt[srv_r] = 1'b0;
          pf_nxt = 1'b1;
          ftag_nxt = a_tag + 14'h0001;
          fbuf_nxt = srv_r;
          fpf_nxt = 1'b1;
        end
      end else begin
        hready_nxt = 1'b0;
        pf_nxt = 1'b1;
        ftag_nxt = a_tag;
        fpf_nxt = 1'b0;
        // Latest filled buffer is flushed for a jump
        fbuf_nxt = (!a_seq && rval_r == 2'b11) ? !srv_r : srv_r;
        rval_nxt[fbuf_nxt] = 1'b0;
      end
    end

    // Array read engine, held off while the sequencer is busy
    unique case (rd_r)
      nrp_pkg::RD_IDLE: begin
        if ((pf_r || pf_nxt) && sq_r == nrp_pkg::SQ_IDLE) begin
          rd_nxt = nrp_pkg::RD_FETCH;
          pcnt_nxt = 2'h0;
          pf_nxt = 1'b0;
        end
      end
      nrp_pkg::RD_FETCH: begin
        pcnt_nxt = pcnt_r + 2'h1;
        if (pcnt_r == 2'(nrp_pkg::ARRAY_READ_CYCLES - 1)) begin
          rd_nxt = nrp_pkg::RD_DONE;
        end
      end
      nrp_pkg::RD_DONE: begin
        rd_nxt = nrp_pkg::RD_IDLE;
        rbuf_nxt[fbuf_r] = rd_corr;
        rtag_nxt[fbuf_r] = ftag_r;
        rval_nxt[fbuf_r] = !rd_dbl;
        if (!fpf_r) begin
          srv_nxt = fbuf_r;
          hrdata_nxt = rd_corr[req_r.addr[2]*32 +: 32];
          hready_nxt = !rd_dbl;
          hresp_nxt = rd_dbl;
          eccerr_nxt = eccerr_r | rd_dbl;
          // Prefetch next sequential block into the other buffer
          pf_nxt = !rd_dbl;
          ftag_nxt = ftag_r + 14'h0001;
          fbuf_nxt = !fbuf_r;
          fpf_nxt = 1'b1;
        end
      end
      default: rd_nxt = nrp_pkg::RD_IDLE;
    endcase
    // Second cycle of the two-cycle error answer
    if (hresp_r && !hready_r) begin
      hready_nxt = 1'b1;
      hresp_nxt = 1'b1;
    end

    // Program sequencer into the spare page
    unique case (sq_r)
      nrp_pkg::SQ_IDLE: begin
        if (i_prog_start) begin
          page_nxt = i_prog_page;
          sq_nxt = nrp_pkg::SQ_ERASE;
          tmr_nxt = 32'(ERASE_CYC - 1);
          torn_nxt = 1'b1;
          rval_nxt = 2'b00;
        end
      end
      nrp_pkg::SQ_ERASE, nrp_pkg::SQ_WRITE, nrp_pkg::SQ_REFRESH: begin
        tmr_nxt = tmr_r - 32'h0000_0001;
        if (tmr_r == 32'h0000_0000) begin
          if (sq_r == nrp_pkg::SQ_ERASE) begin
            sq_nxt = nrp_pkg::SQ_WRITE;
            tmr_nxt = 32'(WRITE_CYC - 1);
          end else begin
            sq_nxt = nrp_pkg::SQ_VERIFY;
            vblk_nxt = 4'h0;
          end
        end
      end
      nrp_pkg::SQ_VERIFY: begin
        vblk_nxt = vblk_r + 4'h1;
        if (i_hard_rdata != abuf_r[vblk_r]) begin
          vfail_nxt = 1'b1;
        end
        if (vblk_r == 4'hf) begin
          sq_nxt = nrp_pkg::SQ_IDLE;
          torn_nxt = 1'b0;
          if (!vfail_nxt) begin
            // Old physical page becomes the new spare
            spare_nxt = map_r[page_r];
            map_nxt[page_r] = spare_r;
          end
          dist_nxt = (dist_r == 10'(DISTURB_PER - 1)) ? 10'h000 : dist_r + 10'h001;
          if (i_disturb_en && dist_r == 10'(DISTURB_PER - 1)) begin
            sq_nxt = nrp_pkg::SQ_REFRESH;
            tmr_nxt = 32'(REFRESH_CYC - 1);
          end
        end
      end
      default: sq_nxt = nrp_pkg::SQ_IDLE;
    endcase

    if (i_repair_valid) begin
      rep_nxt = i_repair_code;
    end
    if (init_s2[0]) begin
      st_nxt = {init_s2[1], 1'b1};
    end
  end

  // ****************************************
  // Registering
  // ****************************************
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sq_r <= nrp_pkg::SQ_IDLE;
      rd_r <= nrp_pkg::RD_IDLE;
      req_r <= '0;
      tmr_r <= 32'h0000_0000;
      dist_r <= 10'h000;
      spare_r <= 6'(nrp_pkg::LOGIC_PAGES);
      for (int i = 0; i < nrp_pkg::LOGIC_PAGES; i++) begin
        map_r[i] <= 6'(i);
      end
      page_r <= 5'h00;
      vblk_r <= 4'h0;
      for (int i = 0; i < nrp_pkg::BLOCKS_PER_PAGE; i++) begin
        abuf_r[i] <= 72'h00_0000_0000_0000_0000;
      end
      rbuf_r[0] <= 64'h0000_0000_0000_0000;
      rbuf_r[1] <= 64'h0000_0000_0000_0000;
      rtag_r[0] <= 14'h0000;
      rtag_r[1] <= 14'h0000;
      rval_r <= 2'h0;
      srv_r <= 1'b0;
      pf_r <= 1'b0;
      pcnt_r <= 2'h0;
      ftag_r <= 14'h0000;
      fbuf_r <= 1'b0;
      fpf_r <= 1'b0;
      pend_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
      vfail_r <= 1'b0;
      eccerr_r <= 1'b0;
      torn_r <= 1'b0;
      rep_r <= nrp_pkg::REPAIR_RESET;
      st_r <= nrp_pkg::STARTUP_RESET;
      pf_s1 <= 2'h0;
      pf_s2 <= 2'h0;
      init_s1 <= 2'h0;
      init_s2 <= 2'h0;
    end else begin
      sq_r <= sq_nxt;
      rd_r <= rd_nxt;
      req_r <= req_nxt;
      tmr_r <= tmr_nxt;
      dist_r <= dist_nxt;
      spare_r <= spare_nxt;
      map_r <= map_nxt;
      page_r <= page_nxt;
      vblk_r <= vblk_nxt;
      abuf_r <= abuf_nxt;
      rbuf_r <= rbuf_nxt;
      rtag_r <= rtag_nxt;
      rval_r <= rval_nxt;
      srv_r <= srv_nxt;
      pf_r <= pf_nxt;
      pcnt_r <= pcnt_nxt;
      ftag_r <= ftag_nxt;
      fbuf_r <= fbuf_nxt;
      fpf_r <= fpf_nxt;
      pend_r <= pend_nxt;
      hrdata_r <= hrdata_nxt;
      hready_r <= hready_nxt;
      hresp_r <= hresp_nxt;
      vfail_r <= vfail_nxt;
      eccerr_r <= eccerr_nxt;
      torn_r <= torn_nxt | (pf_s2[0] & torn_r);
      rep_r <= rep_nxt;
      st_r <= st_nxt;
      pf_s1 <= {1'b0, i_power_fail};
      pf_s2 <= pf_s1;
      init_s1 <= {i_init_fail, i_init_done};
      init_s2 <= init_s1;
    end
  end

  assign o_hrdata = hrdata_r;
  assign o_hreadyout = hready_r;
  assign o_hresp = hresp_r;
  assign o_array_addr = {ftag_r, 3'h0};
  assign o_array_rd = (rd_r == nrp_pkg::RD_FETCH);
  assign o_phys_page = spare_r;
  assign o_erase_en = (sq_r == nrp_pkg::SQ_ERASE);
  assign o_write_en = (sq_r == nrp_pkg::SQ_WRITE) || (sq_r == nrp_pkg::SQ_REFRESH);
  assign o_busy = (sq_r != nrp_pkg::SQ_IDLE);
  assign o_verify_fail = vfail_r;
  assign o_ecc_err = eccerr_r;
  assign o_torn_mark = torn_r;
  assign o_repair_result_status = rep_r;
  assign o_startup_init_status = st_r;
endmodule

/* verification/nrp_checker.sv */
// Port-level concurrent checks for the flash read and program sequencer
`timescale 1ns/1ps
module nrp_checker #(
  parameter int ERASE_CYC = 20,
  parameter int WRITE_CYC = 15,
  parameter int REFRESH_CYC = 35
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic i_hready,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_array_rd,
  input wire logic o_erase_en,
  input wire logic o_write_en,
  input wire logic o_busy,
  input wire logic o_ecc_err,
  input wire logic o_torn_mark
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  int ecnt_r, ecnt_nxt, wcnt_r, wcnt_nxt;
  // Tells a write phase after erase from a refresh write phase
  logic post_er_r, post_er_nxt;
  logic take_rd;
  assign take_rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  // Phase lengths counted here, too long for a repetition
  always_comb begin
    ecnt_nxt = o_erase_en ? ecnt_r + 1 : 0;
    wcnt_nxt = o_write_en ? wcnt_r + 1 : 0;
    post_er_nxt = o_erase_en || (post_er_r && o_write_en);
  end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ecnt_r <= 0;
      wcnt_r <= 0;
      post_er_r <= 1'b0;
    end else begin
      ecnt_r <= ecnt_nxt;
      wcnt_r <= wcnt_nxt;
      post_er_r <= post_er_nxt;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  fetch_len_a: assert property ($rose(o_array_rd) |-> o_array_rd [*3] ##1 !o_array_rd)
    else $error("array read shorter than three cycles");
  read_stall_a: assert property (take_rd && o_busy |=> !o_hreadyout)
    else $error("read not stalled while busy");
  wait_bound_a: assert property (!o_hreadyout && !o_hresp && !o_busy |-> ##[1:8] o_hreadyout)
    else $error("wait states too long");
  erase_len_a: assert property ($fell(o_erase_en) |-> ecnt_r == ERASE_CYC)
    else $error("erase phase length wrong");
  write_len_a: assert property ($fell(o_write_en) |->
    wcnt_r == (post_er_r ? WRITE_CYC : REFRESH_CYC))
    else $error("write phase length wrong");
  erase_write_a: assert property ($fell(o_erase_en) |-> o_write_en)
    else $error("write does not follow erase");
  err_resp_a: assert property (o_hresp && !o_hreadyout |=> o_hresp && o_hreadyout)
    else $error("error response not two cycles");
  ecc_flag_a: assert property ($rose(o_hresp) |-> ##[0:2] o_ecc_err)
    else $error("error response without ecc flag");
  torn_mark_a: assert property ($rose(o_erase_en) |-> ##[0:1] o_torn_mark)
    else $error("torn mark not set at program start");
  cov_fetch: cover property ($rose(o_array_rd));
  cov_prog: cover property ($fell(o_write_en));
  cov_err: cover property ($rose(o_hresp));
endmodule

bind nrp_top nrp_checker #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC),
  .REFRESH_CYC(REFRESH_CYC)) u_nrp_chk (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_hready(i_hready),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_array_rd(o_array_rd), .o_erase_en(o_erase_en), .o_write_en(o_write_en),
  .o_busy(o_busy), .o_ecc_err(o_ecc_err), .o_torn_mark(o_torn_mark)
);

/* verification/nrp_bus_model.sv */
// Bus matrix master and cell array responder facing the sequencer
`timescale 1ns/1ps
module nrp_bus_model (
  input wire logic i_clock,
  input wire logic [16:0] i_array_addr,
  input wire logic i_hreadyout,
  input wire logic [31:0] i_hrdata,
  input wire logic i_hresp,
  output logic o_hsel,
  output logic [16:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [71:0] o_array_rdata,
  output logic [71:0] o_hard_rdata
);
  logic [1:0] err_mode;
  logic hard_bad;
  logic [63:0] blk;
  logic [7:0] chk;
  // Block content is its own address, low word plain and high word inverted, so every word is traceable
  assign blk = {~{15'h0000, i_array_addr}, 15'h0000, i_array_addr};
  // Check bits as the array stores them: data on non-power-of-two positions
  function automatic logic [7:0] enc(input logic [63:0] dt);
    logic [6:0] s;
    int n;
    s = 7'h00;
    n = 0;
    for (int j = 3; j < 128 && n < 64; j++) begin
      if ((j & (j - 1)) != 0) begin
        if (dt[n]) s = s ^ 7'(j);
        n++;
      end
    end
    return {^dt ^ ^s, s};
  endfunction
  assign chk = enc(blk);
  always_comb begin
    o_array_rdata = {chk, blk};
    if (err_mode != 2'h0) o_array_rdata[5] = ~blk[5];
    if (err_mode == 2'h2) o_array_rdata[40] = ~blk[40];
    // Good page mirrors the untouched, all-zero assembly buffer
    o_hard_rdata = hard_bad ? {8'h00, blk} : 72'h00_0000_0000_0000_0000;
  end
  initial begin
    err_mode = 2'h0;
    hard_bad = 1'b0;
    o_hsel = 1'b0;
    o_haddr = 17'h0_0000;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
  end
  task automatic rd(input logic [16:0] a, input logic [1:0] t, output logic [31:0] d,
    output logic r, output int w);
    @(negedge i_clock);
    o_hsel = 1'b1;
    o_haddr = a;
    o_htrans = t;
    while (i_hreadyout !== 1'b1) @(negedge i_clock);
    @(negedge i_clock);
    o_hsel = 1'b0;
    o_htrans = 2'h0;
    o_haddr = ~a;
    w = 0;
    while (i_hreadyout !== 1'b1 && w < 100) begin
      w++;
      @(negedge i_clock);
    end
    d = i_hrdata;
    r = i_hresp;
  endtask
endmodule

/* verification/nvm_read_prefetch_ecc_tb_top.sv */
// Self-checking bench for the flash read prefetch and program sequencer
`timescale 1ns/1ps
module nvm_read_prefetch_ecc_tb_top;
  localparam int ERASE_C = 20;
  localparam int WRITE_C = 15;
  localparam int REFRESH_C = 35;
  typedef struct {
    logic [16:0] addr;
    logic [1:0] trans;
    logic [1:0] err;
    int maxw;
  } nrp_row_t;
  logic i_clock, i_rstn, i_hsel, i_hwrite, i_hready, i_prog_start, i_disturb_en;
  logic i_power_fail, i_init_done, i_init_fail, i_repair_valid;
  logic [16:0] i_haddr, o_array_addr;
  logic [1:0] i_htrans, o_startup_init_status;
  logic [2:0] i_hsize;
  logic [31:0] i_hwdata, o_hrdata, d;
  logic [4:0] i_prog_page;
  logic [71:0] i_array_rdata, i_hard_rdata;
  logic [7:0] i_repair_code, o_repair_result_status;
  logic [5:0] o_phys_page, pp, pp0;
  logic o_hreadyout, o_hresp, o_array_rd, o_erase_en, o_write_en, o_busy;
  logic o_verify_fail, o_ecc_err, o_torn_mark, r;
  int n_mismatch, num_checks, w, len, ne, nw, bad, nref;
  // Miss 8, hit 0, prefetched 4 wait cycles at most
  nrp_row_t rows [8] = '{
    '{17'h0_0000, nrp_pkg::HTRANS_NONSEQ, 2'h0, 8}, '{17'h0_0004, nrp_pkg::HTRANS_SEQ, 2'h0, 0},
    '{17'h0_0008, nrp_pkg::HTRANS_SEQ, 2'h0, 4}, '{17'h0_000C, nrp_pkg::HTRANS_SEQ, 2'h0, 0},
    '{17'h0_0010, nrp_pkg::HTRANS_SEQ, 2'h0, 4}, '{17'h0_0200, nrp_pkg::HTRANS_NONSEQ, 2'h1, 8},
    '{17'h0_0204, nrp_pkg::HTRANS_SEQ, 2'h0, 0}, '{17'h0_0400, nrp_pkg::HTRANS_NONSEQ, 2'h2, 8}};
  assign i_hready = o_hreadyout;
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  nrp_top #(.ERASE_CYC(ERASE_C), .WRITE_CYC(WRITE_C), .REFRESH_CYC(REFRESH_C),
    .DISTURB_PER(4)) DUT (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_prog_start(i_prog_start), .i_prog_page(i_prog_page), .i_disturb_en(i_disturb_en),
    .i_array_rdata(i_array_rdata), .i_hard_rdata(i_hard_rdata), .i_power_fail(i_power_fail),
    .i_init_done(i_init_done), .i_init_fail(i_init_fail), .i_repair_valid(i_repair_valid),
    .i_repair_code(i_repair_code), .o_array_addr(o_array_addr), .o_array_rd(o_array_rd),
    .o_phys_page(o_phys_page), .o_erase_en(o_erase_en), .o_write_en(o_write_en),
    .o_busy(o_busy), .o_verify_fail(o_verify_fail), .o_ecc_err(o_ecc_err),
    .o_torn_mark(o_torn_mark), .o_repair_result_status(o_repair_result_status),
    .o_startup_init_status(o_startup_init_status));
  nrp_bus_model BUS (.i_clock(i_clock), .i_array_addr(o_array_addr), .i_hreadyout(o_hreadyout),
    .i_hrdata(o_hrdata), .i_hresp(o_hresp), .o_hsel(i_hsel), .o_haddr(i_haddr),
    .o_htrans(i_htrans), .o_hwrite(i_hwrite), .o_hsize(i_hsize), .o_array_rdata(i_array_rdata),
    .o_hard_rdata(i_hard_rdata));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [31:0] exp_word(input logic [16:0] a);
    logic [31:0] lo;
    lo = {15'h0000, a[16:3], 3'h0};
    return a[2] ? ~lo : lo;
  endfunction
  task automatic prog(input logic [4:0] pg);
    @(negedge i_clock);
    i_prog_page = pg;
    i_prog_start = 1'b1;
    @(negedge i_clock);
    i_prog_start = 1'b0;
    len = 0;
    ne = 0;
    nw = 0;
    bad = 0;
    while (o_busy === 1'b1 && len < 2000) begin
      len++;
      if (o_erase_en === 1'b1) begin
        ne++;
        pp = o_phys_page;
        if (o_torn_mark !== 1'b1) bad++;
      end
      if (o_write_en === 1'b1) nw++;
      @(negedge i_clock);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    $display("Error watchdog expected end seen timeout");
    results();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {i_rstn, i_prog_start, i_disturb_en, i_power_fail, i_init_done} = 5'h00;
    {i_init_fail, i_repair_valid, i_prog_page, i_repair_code} = 15'h0000;
    i_hwdata = 32'h0000_0000;
    repeat (16) @(negedge i_clock);
    check("reset hreadyout", 1, o_hreadyout);
    check("reset phys page", 6'h20, o_phys_page);
    check("reset repair", nrp_pkg::REPAIR_RESET, o_repair_result_status);
    i_rstn = 1'b1;
    foreach (rows[k]) begin
      BUS.err_mode = rows[k].err;
      BUS.rd(rows[k].addr, rows[k].trans, d, r, w);
      check("hresp", rows[k].err == 2'h2, r);
      if (rows[k].err != 2'h2) check("hrdata", exp_word(rows[k].addr), d);
      check("wait states", 1, w <= rows[k].maxw);
    end
    check("ecc flag", 1, o_ecc_err);
    BUS.err_mode = 2'h0;
    // Idle gaps let each prefetch finish before the next block is asked for
    BUS.rd(17'h0_1000, nrp_pkg::HTRANS_NONSEQ, d, r, w);
    for (int k = 1; k < 3; k++) begin
      repeat (8) @(negedge i_clock);
      BUS.rd(17'h0_1000 + 17'(k * 8), nrp_pkg::HTRANS_SEQ, d, r, w);
      check("prefetched waits", 0, w);
      check("prefetched data", exp_word(17'h0_1000 + 17'(k * 8)), d);
    end
    @(negedge i_clock);
    i_repair_code = 8'hA5;
    i_repair_valid = 1'b1;
    @(negedge i_clock);
    i_repair_valid = 1'b0;
    i_repair_code = 8'h00;
    i_init_done = 1'b1;
    repeat (4) @(negedge i_clock);
    check("repair status", 8'hA5, o_repair_result_status);
    check("startup pass", 2'h1, o_startup_init_status);
    i_init_fail = 1'b1;
    repeat (4) @(negedge i_clock);
    check("startup fail", 2'h3, o_startup_init_status);
    // Refresh every fourth program, so exactly one of four runs long
    i_disturb_en = 1'b1;
    nref = 0;
    for (int k = 0; k < 4; k++) begin
      prog(5'(k));
      if (k == 0) begin
        check("erase cycles", ERASE_C, ne);
        check("write cycles", WRITE_C, nw);
        check("spare page", 6'h20, pp);
        check("torn mark", 0, bad);
        check("verify pass", 0, o_verify_fail);
      end
      if (len >= ERASE_C + WRITE_C + REFRESH_C) nref++;
    end
    check("refresh count", 1, nref);
    BUS.hard_bad = 1'b1;
    pp0 = o_phys_page;
    @(negedge i_clock);
    i_prog_page = 5'h07;
    i_prog_start = 1'b1;
    @(negedge i_clock);
    i_prog_start = 1'b0;
    BUS.rd(17'h0_0800, nrp_pkg::HTRANS_NONSEQ, d, r, w);
    check("stall length", 1, w > ERASE_C + WRITE_C);
    check("busy after stall", 0, o_busy);
    check("stalled data", exp_word(17'h0_0800), d);
    check("verify fail", 1, o_verify_fail);
    check("page kept", pp0, o_phys_page);
    i_rstn = 1'b0;
    @(negedge i_clock);
    check("second reset status", nrp_pkg::STARTUP_RESET, o_startup_init_status);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_clock);
    results();
  end
endmodule
